//--- hdl/sfb_core.sv
// Purpose: Special function register bank, bank selection and status flags.
// Assumes: The core issues at most one read or write per cycle on MEM_*.
// Notes: Read data appears on MEM_RDATA one clock after MEM_RD.
// Operation
// [R1] Bank code 00 selects bank 0, 01 bank 1.
// [R2] First window and pointer always reach bank 0.
// [R3] EEPROM port at 40H bank 1, second window.
// [R4] Resets clear bank, except halted watchdog expiry.
// [R5] Special registers reachable from either bank.
// [R6] Direct addressing always reaches bank 0.
// [R7] Counter-low write jumps in page, one dummy.
// [R8] Table read stores high byte in table-high.
// [R9] Status writes never touch halted or expiry.
// [R10] Carry from add, no-borrow, rotate-through-carry.
// [R11] Half flag from low-nibble carry or no-borrow.
// [R12] Zero flag set on zero result.
// [R13] Overflow when top-bit carries in and out differ.
// [R14] Halted flag: power-up/watchdog-clear clear, halt sets.
// [R15] Expiry flag: power-up/clear/halt clear, expiry sets.
// [R16] Status not saved on interrupt or call.
// [R17] Global gate cleared on entry, set on return.
// [R18] Direction bit one input, zero output.
// [R19] Each modulator has its own duty register.
// [R20] Eight-bit result single register, nine-bit split.
// [R21] Timer is preloadable 8-bit up-counter.
// [R22] Unused special locations read zero.
// [R23] Small-RAM pointers read top bit one.
// [R24] Bank register keeps only its low bit.
`timescale 1ns/100ps
`default_nettype none
module sfb_core
	import sfb_pkg::*;
#(
	parameter int RAM_BYTES = 64,
	parameter int ADC_BITS = 9,
	parameter bit PTR_TOP_IMPL = 1'b0
)
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] MEM_ADDR,
	input wire logic MEM_RD,
	input wire logic MEM_WR,
	input wire logic [7:0] MEM_WDATA,
	output logic [7:0] MEM_RDATA,
	input wire logic ALU_UPD,
	input wire logic [7:0] ALU_A,
	input wire logic [7:0] ALU_B,
	input wire logic ALU_CIN,
	input wire logic ALU_SUB,
	input wire logic ROT_UPD,
	input wire logic ROT_CARRY,
	input wire logic LOGIC_UPD,
	input wire logic [7:0] LOGIC_RESULT,
	input wire logic HALT_EXEC,
	input wire logic WDT_CLR_EXEC,
	input wire logic WDT_TIMEOUT,
	input wire logic CHIP_RESET_REQ,
	input wire logic IRQ_ENTRY,
	input wire logic IRQ_RETURN,
	input wire logic [7:0] PC_LOW_NOW,
	input wire logic TBL_RD_DONE,
	input wire logic [15:0] TBL_WORD,
	input wire logic TMR_TICK,
	input wire logic ADC_DONE,
	input wire logic [ADC_BITS-1:0] ADC_RESULT,
	input wire logic [7:0] PORT_PIN_IN,
	input wire logic EE_DO_IN,
	output logic [7:0] STATUS_FLAGS,
	output logic BANK_SEL,
	output logic IRQ_GLOBAL_EN,
	output logic PC_JUMP,
	output logic [7:0] PC_JUMP_LOW,
	output logic DUMMY_CYCLE,
	output logic [7:0] TABLE_POINTER,
	output logic TMR_OVF,
	output logic [7:0] PORT_OUT,
	output logic [7:0] PORT_OE,
	output logic [7:0] PWM0_DUTY,
	output logic [7:0] PWM1_DUTY,
	output logic EE_CS,
	output logic EE_SK,
	output logic EE_DI
);
	logic [7:0] ptr_a; // First indirect pointer.
	logic [7:0] ptr_b; // Second indirect pointer.
	logic [7:0] tbl_hi; // High byte of the last table word.
	logic [7:0] irq_ctl; // Interrupt control register.
	logic [7:0] tmr; // Timer count.
	logic [7:0] adc_hi; // Result high byte, or the whole 8-bit result.
	logic [7:0] adc_lo; // Result low byte; lsb sits in bit 7.
	logic [7:0] ram [RAM_BYTES]; // General purpose bytes of bank 0.
	logic [8:0] sync1, sync2, sync3; // Pin synchronisers, EEPROM data on top.
	logic [8:0] pin_stable; // Filtered pin levels.
	logic ind_a, ind_b; // Access goes through a window.
	logic [7:0] eff_addr; // Resolved address.
	logic eff_bank; // Resolved bank.
	sfb_tgt_t tgt; // Kind of location reached.
	logic sfr_wr; // Write landing on a special register.
	localparam int RAM_AW = $clog2(RAM_BYTES); // Index width of the general purpose array.
	logic [RAM_AW-1:0] ram_idx; // Offset into the general purpose array.
	logic [7:0] sfr_val; // Special register read value.
	logic [7:0] rd_val; // Final read value.
	logic fc_carry, fc_half, fc_zero, fc_ovf; // Flags from the calculator.
	logic [3:0] next_arith; // Next C, AC, Z, OV.
	logic next_pdf, next_to; // Next halted and expiry flags.
	logic next_bank; // Next bank select.
	logic [7:0] next_irq; // Next interrupt control.
	logic [7:0] next_tmr; // Next timer count.

	// Classify a resolved address into the location it reaches.
	function automatic sfb_tgt_t resolve(input logic [7:0] addr, input logic bank);
		sfb_tgt_t t;
		t = SFB_TGT_NONE;
		if (addr < SFB_GPR_BASE)
		begin
			// Windows are not real storage: via a pointer they read zero.
			if (addr != SFB_IND_A && addr != SFB_IND_B)
			begin
				t = SFB_TGT_SFR; // R5
			end
		end
		else if (bank == SFB_BANK1)
		begin
			if (addr == SFB_EEPORT)
			begin
				t = SFB_TGT_EEPORT; // R3
			end
		end
		else if ({24'h0, addr} < 32'(int'(SFB_GPR_BASE) + RAM_BYTES))
		begin
			t = SFB_TGT_RAM;
		end
		return t;
	endfunction

	// Window decode and address resolution.
	assign ind_a = (MEM_ADDR == SFB_IND_A);
	assign ind_b = (MEM_ADDR == SFB_IND_B);
	assign eff_addr = ind_a ? ptr_a : (ind_b ? ptr_b : MEM_ADDR);
	// Only the second window honours the bank; direct and first window stay in bank 0.
	assign eff_bank = ind_b ? BANK_SEL : SFB_BANK0; // R1 R2 R6
	assign tgt = resolve(eff_addr, eff_bank);
	assign sfr_wr = MEM_WR && (tgt == SFB_TGT_SFR);
	// Cut to the array's index width; only RAM targets ever use the index.
	assign ram_idx = RAM_AW'(eff_addr - SFB_GPR_BASE);

	sfb_flag_calc u_flag_calc
	(
		.a(ALU_A),
		.b(ALU_B),
		.cin(ALU_CIN),
		.sub(ALU_SUB),
		.carry(fc_carry),
		.half(fc_half),
		.zero(fc_zero),
		.ovf(fc_ovf)
	);

	// Special register read mux.
	always_comb
	begin
		sfr_val = SFB_ZERO_RST;
		case (eff_addr)
			// Pointers without a top bit read it back as one.
			SFB_PTR_A: sfr_val = {PTR_TOP_IMPL ? ptr_a[7] : 1'b1, ptr_a[6:0]}; // R23
			SFB_PTR_B: sfr_val = {PTR_TOP_IMPL ? ptr_b[7] : 1'b1, ptr_b[6:0]}; // R23
			SFB_BANK: sfr_val = {7'h00, BANK_SEL}; // R24
			SFB_PCLOW: sfr_val = PC_LOW_NOW;
			SFB_TBLPTR: sfr_val = TABLE_POINTER;
			SFB_TBLHI: sfr_val = tbl_hi;
			SFB_STAT: sfr_val = STATUS_FLAGS;
			SFB_IRQC: sfr_val = irq_ctl;
			SFB_TIMER: sfr_val = tmr;
			// Input bits show the pin, output bits show the latch.
			SFB_PORT: sfr_val = (PORT_OE & PORT_OUT) | (~PORT_OE & pin_stable[7:0]);
			SFB_PORTDIR: sfr_val = ~PORT_OE;
			SFB_PWM0: sfr_val = PWM0_DUTY;
			SFB_PWM1: sfr_val = PWM1_DUTY;
			SFB_ADCHI: sfr_val = adc_hi;
			SFB_ADCLO: sfr_val = adc_lo;
			default: sfr_val = SFB_ZERO_RST; // R22
		endcase
	end

	// Final read selection by location kind.
	always_comb
	begin
		unique case (tgt)
			SFB_TGT_SFR: rd_val = sfr_val;
			SFB_TGT_RAM: rd_val = ram[ram_idx];
			SFB_TGT_EEPORT: rd_val = {pin_stable[8], EE_DI, EE_SK, EE_CS, 4'h0}; // R3
			SFB_TGT_NONE: rd_val = SFB_ZERO_RST; // R22
		endcase
	end

	// Arithmetic flags; one update source per cycle, ALU first.
	always_comb
	begin
		next_arith = STATUS_FLAGS[3:0];
		if (ALU_UPD)
		begin
			next_arith = {fc_ovf, fc_zero, fc_half, fc_carry}; // R10 R11 R12 R13
		end
		else if (ROT_UPD)
		begin
			next_arith[SFB_ST_C] = ROT_CARRY; // R10
		end
		else if (LOGIC_UPD)
		begin
			next_arith[SFB_ST_Z] = (LOGIC_RESULT == 8'h00); // R12
		end
		else if (sfr_wr && eff_addr == SFB_STAT)
		begin
			// Writes reach only the low four bits.
			next_arith = MEM_WDATA[3:0]; // R9
		end
	end

	// Halt sets, clear wins only when nothing sets.
	assign next_pdf = HALT_EXEC ? 1'b1 : (WDT_CLR_EXEC ? 1'b0 : STATUS_FLAGS[SFB_ST_PDF]); // R14
	assign next_to = WDT_TIMEOUT ? 1'b1 :
		((WDT_CLR_EXEC || HALT_EXEC) ? 1'b0 : STATUS_FLAGS[SFB_ST_TO]); // R15

	// A watchdog expiry while halted is a wake-up and must keep the bank.
	assign next_bank = (CHIP_RESET_REQ || (WDT_TIMEOUT && !STATUS_FLAGS[SFB_ST_PDF])) ? SFB_BANK0 :
		((sfr_wr && eff_addr == SFB_BANK) ? MEM_WDATA[0] : BANK_SEL); // R4 R24

	// Interrupt entry clears the gate, return sets it; status is left alone.
	always_comb
	begin
		next_irq = irq_ctl;
		if (sfr_wr && eff_addr == SFB_IRQC)
		begin
			next_irq = MEM_WDATA;
		end
		if (IRQ_ENTRY)
		begin
			next_irq[SFB_IRQ_GATE] = 1'b0; // R17 R16
		end
		else if (IRQ_RETURN)
		begin
			next_irq[SFB_IRQ_GATE] = 1'b1; // R17
		end
	end

	// Preload wins over a tick in the same cycle.
	assign next_tmr = (sfr_wr && eff_addr == SFB_TIMER) ? MEM_WDATA :
		(TMR_TICK ? tmr + 8'h01 : tmr); // R21
	assign IRQ_GLOBAL_EN = irq_ctl[SFB_IRQ_GATE];

	// Status, bank and interrupt control; power-up clears every flag.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			STATUS_FLAGS <= SFB_ZERO_RST;
			BANK_SEL <= SFB_BANK0;
			irq_ctl <= SFB_ZERO_RST;
		end
		else
		begin
			STATUS_FLAGS <= {2'b00, next_to, next_pdf, next_arith};
			BANK_SEL <= next_bank;
			irq_ctl <= next_irq;
		end
	end

	// Pointers and table registers.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ptr_a <= SFB_ZERO_RST;
			ptr_b <= SFB_ZERO_RST;
			TABLE_POINTER <= SFB_ZERO_RST;
			tbl_hi <= SFB_ZERO_RST;
		end
		else
		begin
			if (sfr_wr && eff_addr == SFB_PTR_A)
			begin
				ptr_a <= MEM_WDATA;
			end
			if (sfr_wr && eff_addr == SFB_PTR_B)
			begin
				ptr_b <= MEM_WDATA;
			end
			if (sfr_wr && eff_addr == SFB_TBLPTR)
			begin
				TABLE_POINTER <= MEM_WDATA;
			end
			// The low byte goes to the core's own destination.
			if (TBL_RD_DONE)
			begin
				tbl_hi <= TBL_WORD[15:8]; // R8
			end
		end
	end

	// Counter-low writes: an in-page jump plus one inserted dummy cycle.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			PC_JUMP <= 1'b0;
			DUMMY_CYCLE <= 1'b0;
			PC_JUMP_LOW <= SFB_ZERO_RST;
		end
		else
		begin
			PC_JUMP <= sfr_wr && eff_addr == SFB_PCLOW; // R7
			DUMMY_CYCLE <= sfr_wr && eff_addr == SFB_PCLOW; // R7
			if (sfr_wr && eff_addr == SFB_PCLOW)
			begin
				PC_JUMP_LOW <= MEM_WDATA; // R7
			end
		end
	end

	// Timer, modulator duties and converter result.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			tmr <= SFB_ZERO_RST;
			TMR_OVF <= 1'b0;
			PWM0_DUTY <= SFB_ZERO_RST;
			PWM1_DUTY <= SFB_ZERO_RST;
			adc_hi <= SFB_ZERO_RST;
			adc_lo <= SFB_ZERO_RST;
		end
		else
		begin
			tmr <= next_tmr;
			TMR_OVF <= TMR_TICK && tmr == 8'hff && !(sfr_wr && eff_addr == SFB_TIMER); // R21
			if (sfr_wr && eff_addr == SFB_PWM0)
			begin
				PWM0_DUTY <= MEM_WDATA; // R19
			end
			if (sfr_wr && eff_addr == SFB_PWM1)
			begin
				PWM1_DUTY <= MEM_WDATA; // R19
			end
			// The narrow variant fills one register and leaves the low byte zero.
			if (ADC_DONE)
			begin
				adc_hi <= ADC_RESULT[ADC_BITS-1 -: 8]; // R20
				adc_lo <= (ADC_BITS > 8) ? {ADC_RESULT[0], 7'h00} : SFB_ZERO_RST; // R20
			end
		end
	end

	// Port latch, direction and EEPROM port pins.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			PORT_OUT <= SFB_ZERO_RST;
			PORT_OE <= ~SFB_PORTDIR_RST;
			EE_CS <= 1'b0;
			EE_SK <= 1'b0;
			EE_DI <= 1'b0;
		end
		else
		begin
			if (sfr_wr && eff_addr == SFB_PORT)
			begin
				PORT_OUT <= MEM_WDATA;
			end
			// A one makes the pin an input, so the drive enable is its inverse.
			if (sfr_wr && eff_addr == SFB_PORTDIR)
			begin
				PORT_OE <= ~MEM_WDATA; // R18
			end
			if (MEM_WR && tgt == SFB_TGT_EEPORT)
			begin
				EE_CS <= MEM_WDATA[SFB_EE_CS]; // R3
				EE_SK <= MEM_WDATA[SFB_EE_SK];
				EE_DI <= MEM_WDATA[SFB_EE_DI];
			end
		end
	end

	// Three-stage pin synchroniser; a level counts once stages two and three agree.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
			sync3 <= 9'h000;
			pin_stable <= 9'h000;
		end
		else
		begin
			sync1 <= {EE_DO_IN, PORT_PIN_IN};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_stable <= (sync2 & ~(sync2 ^ sync3)) | (pin_stable & (sync2 ^ sync3));
		end
	end

	// General purpose memory; contents are undefined after power-up.
	always_ff @(posedge CORE_CLK)
	begin
		if (MEM_WR && tgt == SFB_TGT_RAM)
		begin
			ram[ram_idx] <= MEM_WDATA;
		end
	end

	// Registered read data, held between reads.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			MEM_RDATA <= SFB_ZERO_RST;
		end
		else if (MEM_RD)
		begin
			MEM_RDATA <= rd_val;
		end
	end
endmodule // sfb_core
`default_nettype wire

//--- hdl/sfb_pkg.sv
// Purpose: Shared constants and types for the special-function register bank.
// Assumes: One clock domain; the core presents one data-memory access per cycle.
// Notes: Offsets are data-memory addresses as the core issues them.
`default_nettype none
package sfb_pkg;
	// Data-memory offsets of the special function registers.
	localparam logic [7:0] SFB_IND_A = 8'h00;
	localparam logic [7:0] SFB_PTR_A = 8'h01;
	localparam logic [7:0] SFB_IND_B = 8'h02;
	localparam logic [7:0] SFB_PTR_B = 8'h03;
	localparam logic [7:0] SFB_BANK = 8'h04;
	localparam logic [7:0] SFB_PCLOW = 8'h06;
	localparam logic [7:0] SFB_TBLPTR = 8'h07;
	localparam logic [7:0] SFB_TBLHI = 8'h08;
	localparam logic [7:0] SFB_STAT = 8'h0a;
	localparam logic [7:0] SFB_IRQC = 8'h0b;
	localparam logic [7:0] SFB_TIMER = 8'h0d;
	localparam logic [7:0] SFB_PORT = 8'h12;
	localparam logic [7:0] SFB_PORTDIR = 8'h13;
	localparam logic [7:0] SFB_PWM0 = 8'h1a;
	localparam logic [7:0] SFB_PWM1 = 8'h1b;
	localparam logic [7:0] SFB_ADCHI = 8'h24;
	localparam logic [7:0] SFB_ADCLO = 8'h25;
	// First general purpose byte of bank 0, and the EEPROM port in bank 1.
	localparam logic [7:0] SFB_GPR_BASE = 8'h40;
	localparam logic [7:0] SFB_EEPORT = 8'h40;
	// Bank select codes.
	localparam logic SFB_BANK0 = 1'b0;
	localparam logic SFB_BANK1 = 1'b1;
	// Status register bit positions.
	localparam int SFB_ST_C = 0;
	localparam int SFB_ST_AC = 1;
	localparam int SFB_ST_Z = 2;
	localparam int SFB_ST_OV = 3;
	localparam int SFB_ST_PDF = 4;
	localparam int SFB_ST_TO = 5;
	// Interrupt control: global gate position.
	localparam int SFB_IRQ_GATE = 0;
	// EEPROM port register bit positions; bits 3..0 read as zero.
	localparam int SFB_EE_CS = 4;
	localparam int SFB_EE_SK = 5;
	localparam int SFB_EE_DI = 6;
	localparam int SFB_EE_DO = 7;
	// Reset values.
	localparam logic [7:0] SFB_ZERO_RST = 8'h00;
	localparam logic [7:0] SFB_PORTDIR_RST = 8'hff;
	// Kind of location an access resolves to.
	typedef enum logic [1:0] {SFB_TGT_SFR, SFB_TGT_RAM, SFB_TGT_EEPORT, SFB_TGT_NONE} sfb_tgt_t;
endpackage
`default_nettype wire

//--- hdl/sfb_flag_calc.sv
// Purpose: Arithmetic flag evaluation for add and subtract operations.
// Assumes: Subtract is presented as a plus inverted b plus carry in.
// Notes: Purely combinational; the register bank stores the results.
`timescale 1ns/100ps
`default_nettype none
module sfb_flag_calc
(
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	input wire logic sub,
	output logic carry,
	output logic half,
	output logic zero,
	output logic ovf
);
	logic [7:0] b_eff; // Operand b after inversion for subtract.
	logic [4:0] low_sum; // Low-nibble sum with its carry.
	logic [7:0] low7_sum; // Bits 6..0 sum; bit 7 is carry into the top bit.
	logic [8:0] full_sum; // Whole sum with carry out.

	// Subtract without borrow leaves a carry, so carry means no borrow.
	assign b_eff = sub ? ~b : b;
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	assign low7_sum = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
	assign full_sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
	assign carry = full_sum[8]; // R10
	assign half = low_sum[4]; // R11
	assign zero = (full_sum[7:0] == 8'h00); // R12
	assign ovf = low7_sum[7] ^ full_sum[8]; // R13
endmodule // sfb_flag_calc
`default_nettype wire

//--- testbench/sfb_core_checker.sv
// Purpose: Concurrent checks on the special-function register bank ports.
// Assumes: One clock domain; SYS_RST is the asynchronous power-up reset.
// Notes: Attached to every instance of the bank by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module sfb_core_checker
	import sfb_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] MEM_ADDR,
	input wire logic MEM_WR,
	input wire logic [7:0] MEM_WDATA,
	input wire logic HALT_EXEC,
	input wire logic WDT_CLR_EXEC,
	input wire logic WDT_TIMEOUT,
	input wire logic CHIP_RESET_REQ,
	input wire logic IRQ_ENTRY,
	input wire logic IRQ_RETURN,
	input wire logic [7:0] STATUS_FLAGS,
	input wire logic BANK_SEL,
	input wire logic IRQ_GLOBAL_EN,
	input wire logic PC_JUMP,
	input wire logic [7:0] PC_JUMP_LOW,
	input wire logic DUMMY_CYCLE,
	input wire logic [7:0] PORT_OE
);
	// Every check samples on the core clock and sleeps through reset.
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	pc_jump_a: assert property (MEM_WR && MEM_ADDR == SFB_PCLOW |=>
		PC_JUMP && DUMMY_CYCLE && PC_JUMP_LOW == $past(MEM_WDATA))
		else $error("counter-low write gave no jump");
	gate_entry_a: assert property (IRQ_ENTRY |=> !IRQ_GLOBAL_EN)
		else $error("gate still open after entry");
	gate_return_a: assert property (IRQ_RETURN && !IRQ_ENTRY && !MEM_WR |=> IRQ_GLOBAL_EN)
		else $error("gate closed after return");
	halt_sets_a: assert property (HALT_EXEC |=> STATUS_FLAGS[SFB_ST_PDF])
		else $error("halt left halted flag clear");
	expiry_sets_a: assert property (WDT_TIMEOUT |=> STATUS_FLAGS[SFB_ST_TO])
		else $error("expiry left flag clear");
	sys_flags_a: assert property (!HALT_EXEC && !WDT_CLR_EXEC && !WDT_TIMEOUT |=>
		$stable(STATUS_FLAGS[5:4]))
		else $error("halted or expiry flag moved without cause");
	bank_clear_a: assert property (CHIP_RESET_REQ && !MEM_WR |=> !BANK_SEL)
		else $error("bank kept over chip reset");
	bank_keep_a: assert property (WDT_TIMEOUT && STATUS_FLAGS[SFB_ST_PDF] &&
		!CHIP_RESET_REQ && !MEM_WR |=> $stable(BANK_SEL))
		else $error("bank moved on halted expiry");
	port_dir_a: assert property (MEM_WR && MEM_ADDR == SFB_PORTDIR |=>
		PORT_OE == ~$past(MEM_WDATA))
		else $error("drive enables do not invert direction");
endmodule // sfb_core_checker

bind sfb_core sfb_core_checker i_chk (.*);
`default_nettype wire

//--- testbench/sfb_cpu_model.sv
// Purpose: Behavioural model of the core's data-memory port.
// Assumes: Strobes change just after a rising edge and hold to the sampling edge.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module sfb_cpu_model
(
	input wire logic CORE_CLK,
	input wire logic [7:0] MEM_RDATA,
	output logic [7:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [7:0] MEM_WDATA
);
	// Idle port at time zero, with no strobe raised.
	initial
	begin
		MEM_ADDR = 8'hff;
		MEM_RD = 1'b0;
		MEM_WR = 1'b0;
		MEM_WDATA = 8'hff;
	end
	// One write; the byte lands at the edge that samples the strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		MEM_ADDR <= a;
		MEM_WDATA <= d;
		MEM_WR <= 1'b1;
		@(posedge CORE_CLK);
		MEM_WR <= 1'b0;
		MEM_ADDR <= ~a;
		MEM_WDATA <= ~d;
		#1;
	endtask
	// One read; the registered answer is settled just after the read edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CORE_CLK);
		MEM_ADDR <= a;
		MEM_RD <= 1'b1;
		@(posedge CORE_CLK);
		MEM_RD <= 1'b0;
		MEM_ADDR <= ~a;
		#1;
		d = MEM_RDATA;
	endtask
endmodule // sfb_cpu_model
`default_nettype wire

//--- testbench/sfb_core_bench.sv
// Purpose: Self-checking bench for the special-function register bank.
// Assumes: Default parameters: 64 RAM bytes, 9-bit converter, narrow pointers.
// Notes: Register and flag cases run from a row table; the rest are by hand.
`timescale 1ns/100ps
`default_nettype none
module sfb_core_bench;
	import sfb_pkg::*;
	logic CORE_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [7:0] ALU_A = 8'h00, ALU_B = 8'h00, LOGIC_RESULT = 8'h01;
	logic ALU_CIN = 1'b0, ALU_SUB = 1'b0, ROT_CARRY = 1'b0, EE_DO_IN = 1'b1;
	logic [7:0] PC_LOW_NOW = 8'h12, PORT_PIN_IN = 8'h3c;
	logic [15:0] TBL_WORD = 16'h0000;
	logic [8:0] ADC_RESULT = 9'h000;
	logic [11:0] ev = 12'h000;
	wire logic ALU_UPD, ROT_UPD, LOGIC_UPD, HALT_EXEC, WDT_CLR_EXEC, WDT_TIMEOUT;
	wire logic CHIP_RESET_REQ, IRQ_ENTRY, IRQ_RETURN, TBL_RD_DONE, TMR_TICK, ADC_DONE;
	wire logic [7:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, STATUS_FLAGS, PC_JUMP_LOW;
	wire logic [7:0] TABLE_POINTER, PORT_OUT, PORT_OE, PWM0_DUTY, PWM1_DUTY;
	wire logic MEM_RD, MEM_WR, BANK_SEL, IRQ_GLOBAL_EN, PC_JUMP, DUMMY_CYCLE, TMR_OVF;
	wire logic EE_CS, EE_SK, EE_DI;
	int err_count = 0;
	int n_tests = 0;
	logic [7:0] ad, wd, ex, st;
	logic [17:0] op;
	logic [3:0] fl;
	// Rows: address, write data, readback, then operands, carry/sub and flags.
	logic [45:0] rows [9] = '{
		{SFB_PWM0, 8'h11, 8'h11, 8'hff, 8'h01, 2'b00, 4'h7},
		{SFB_PWM1, 8'h22, 8'h22, 8'h7f, 8'h01, 2'b00, 4'ha},
		{SFB_TBLPTR, 8'h33, 8'h33, 8'h05, 8'h03, 2'b11, 4'h3},
		{SFB_BANK, 8'hff, 8'h01, 8'h03, 8'h05, 2'b11, 4'h0},
		{SFB_TBLHI, 8'h55, 8'h00, 8'h80, 8'h01, 2'b11, 4'h9},
		{8'h30, 8'h77, 8'h00, 8'h08, 8'h08, 2'b10, 4'h2},
		{8'h7f, 8'h9a, 8'h9a, 8'h00, 8'h00, 2'b00, 4'h4},
		{SFB_PTR_A, 8'h41, 8'hc1, 8'hff, 8'hff, 2'b11, 4'h7},
		{8'h80, 8'h05, 8'h00, 8'h40, 8'h40, 2'b00, 4'h8}};

	// Event pulses share one vector so a single task can raise any of them.
	assign {ADC_DONE, TMR_TICK, TBL_RD_DONE, IRQ_RETURN, IRQ_ENTRY, CHIP_RESET_REQ,
		WDT_TIMEOUT, WDT_CLR_EXEC, HALT_EXEC, LOGIC_UPD, ROT_UPD, ALU_UPD} = ev;

	sfb_cpu_model i_cpu (.CORE_CLK, .MEM_RDATA, .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA);

	sfb_core i_dut (.CORE_CLK, .SYS_RST, .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA,
		.MEM_RDATA, .ALU_UPD, .ALU_A, .ALU_B, .ALU_CIN, .ALU_SUB, .ROT_UPD, .ROT_CARRY,
		.LOGIC_UPD, .LOGIC_RESULT, .HALT_EXEC, .WDT_CLR_EXEC, .WDT_TIMEOUT,
		.CHIP_RESET_REQ, .IRQ_ENTRY, .IRQ_RETURN, .PC_LOW_NOW, .TBL_RD_DONE, .TBL_WORD,
		.TMR_TICK, .ADC_DONE, .ADC_RESULT, .PORT_PIN_IN, .EE_DO_IN, .STATUS_FLAGS,
		.BANK_SEL, .IRQ_GLOBAL_EN, .PC_JUMP, .PC_JUMP_LOW, .DUMMY_CYCLE, .TABLE_POINTER,
		.TMR_OVF, .PORT_OUT, .PORT_OE, .PWM0_DUTY, .PWM1_DUTY, .EE_CS, .EE_SK, .EE_DI);

	// Free-running 100 MHz core clock.
	initial
	begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// Counts every comparison; case inequality so an unknown never matches.
	task automatic chk(input string nm, input logic [15:0] exv, input logic [15:0] got);
		n_tests++;
		if (got !== exv)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exv, got);
		end
	endtask
	// Reads a location through the core model and compares the byte.
	task automatic rc(input logic [7:0] a, input logic [7:0] exv, input string nm);
		logic [7:0] v;
		i_cpu.rd(a, v);
		chk(nm, {8'h00, exv}, {8'h00, v});
	endtask
	// Raises one event input for exactly one cycle, then lets its effect settle.
	task automatic pulse(input int i);
		@(posedge CORE_CLK);
		ev[i] <= 1'b1;
		@(posedge CORE_CLK);
		ev <= '0;
		#1;
	endtask
	task automatic summarize;
		$display("Checks made %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Guard against a hang: the whole sequence needs well under 1000 cycles.
	initial
	begin
		#20000;
		err_count++;
		summarize();
	end

	initial
	begin
		repeat (5) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		#1;
		chk("reset status", 8'h00, STATUS_FLAGS);
		chk("reset bank", 1'b0, BANK_SEL);
		chk("reset drive", 8'h00, PORT_OE);
		$display("test reset done");
		// Each row writes and reads a location, then runs one arithmetic update.
		for (int i = 0; i < 9; i++)
		begin
			{ad, wd, ex, op, fl} = rows[i];
			i_cpu.wr(ad, wd);
			rc(ad, ex, "readback");
			@(posedge CORE_CLK);
			{ALU_A, ALU_B, ALU_CIN, ALU_SUB} <= op;
			pulse(0);
			chk("alu flags", fl, STATUS_FLAGS[3:0]);
		end
		chk("duty outputs", 16'h1122, {PWM0_DUTY, PWM1_DUTY});
		chk("table pointer", 8'h33, TABLE_POINTER);
		$display("test rows done");
		// Bank 1 is selected here; the first window must still reach bank 0.
		i_cpu.wr(8'h41, 8'h5a);
		rc(SFB_IND_A, 8'h5a, "window a");
		i_cpu.wr(SFB_PTR_B, SFB_EEPORT);
		i_cpu.wr(SFB_IND_B, 8'hf0);
		chk("eeprom pins", 3'b111, {EE_DI, EE_SK, EE_CS});
		rc(SFB_IND_B, 8'hf0, "eeprom port");
		$display("test windows done");
		pulse(6);
		chk("chip reset bank", 1'b0, BANK_SEL);
		i_cpu.wr(SFB_BANK, 8'h01);
		pulse(3);
		pulse(5);
		chk("halted expiry bank", 1'b1, BANK_SEL);
		i_cpu.wr(SFB_STAT, 8'h00);
		chk("status write", 8'h30, STATUS_FLAGS);
		pulse(4);
		chk("after clear", 2'b00, STATUS_FLAGS[5:4]);
		pulse(3);
		chk("after halt", 2'b01, STATUS_FLAGS[5:4]);
		pulse(4);
		pulse(5);
		chk("running expiry bank", 1'b0, BANK_SEL);
		$display("test flags done");
		i_cpu.wr(SFB_PCLOW, 8'h3c);
		chk("jump", {2'b11, 8'h3c}, {PC_JUMP, DUMMY_CYCLE, PC_JUMP_LOW});
		@(posedge CORE_CLK);
		TBL_WORD <= 16'hbeef;
		pulse(9);
		rc(SFB_TBLHI, 8'hbe, "table high");
		i_cpu.wr(SFB_IRQC, 8'h01);
		st = STATUS_FLAGS;
		pulse(7);
		chk("gate on entry", 1'b0, IRQ_GLOBAL_EN);
		chk("status kept", st, STATUS_FLAGS);
		pulse(8);
		chk("gate on return", 1'b1, IRQ_GLOBAL_EN);
		$display("test jump table irq done");
		// Low nibble inputs read pins, high nibble outputs read the latch.
		i_cpu.wr(SFB_PORTDIR, 8'h0f);
		i_cpu.wr(SFB_PORT, 8'ha5);
		chk("port drive", 16'hf0a5, {PORT_OE, PORT_OUT});
		rc(SFB_PORT, 8'hac, "port read");
		@(posedge CORE_CLK);
		ADC_RESULT <= 9'h1ab;
		pulse(11);
		rc(SFB_ADCHI, 8'hd5, "result high");
		rc(SFB_ADCLO, 8'h80, "result low");
		i_cpu.wr(SFB_TIMER, 8'hfe);
		pulse(10);
		rc(SFB_TIMER, 8'hff, "timer count");
		pulse(10);
		chk("timer overflow", 1'b1, TMR_OVF);
		rc(SFB_TIMER, 8'h00, "timer wrap");
		@(posedge CORE_CLK);
		ROT_CARRY <= 1'b1;
		LOGIC_RESULT <= 8'h00;
		pulse(1);
		chk("rotate carry", 1'b1, STATUS_FLAGS[SFB_ST_C]);
		pulse(2);
		chk("logic zero", 1'b1, STATUS_FLAGS[SFB_ST_Z]);
		$display("test peripherals done");
		// A power-up reset in mid-run must clear bank, gate and flags again.
		i_cpu.wr(SFB_BANK, 8'h01);
		@(posedge CORE_CLK);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		#1;
		chk("second reset", 16'h0000, {BANK_SEL, IRQ_GLOBAL_EN, STATUS_FLAGS});
		$display("test second reset done");
		summarize();
	end
endmodule // sfb_core_bench
`default_nettype wire
